// ==== src/lbt_pkg.sv ====
// Purpose: shared constants and types of the loopback and bit-error test block
// Assumes: 50 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes: field positions and offsets are used by the bus slave and the bench
package lbt_pkg;

    // ----------------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned BER_BIT_RATE_HZ = 9600;
    localparam int unsigned BER_BIT_CYCLES = CLK_HZ / BER_BIT_RATE_HZ;
    localparam int unsigned ERR_LED_MS = 50;
    localparam int unsigned ERR_LED_CYCLES = (CLK_HZ / 1000) * ERR_LED_MS;
    localparam int unsigned ERR_INSERT_BITS = 128;

    // ----------------------------------------------------------------------
    // pattern sequence
    // ----------------------------------------------------------------------
    localparam int unsigned PRBS_LEN = 9;
    localparam int unsigned PRBS_TAP = 5;
    localparam logic [8:0] PRBS_SEED = 9'h1FF;

    // ----------------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ERR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;

    localparam int unsigned CTRL_SW_DISABLE_BIT = 0;
    localparam int unsigned CTRL_CNT_CLEAR_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    localparam int unsigned ST_LOCAL_BIT = 0;
    localparam int unsigned ST_REMOTE_BIT = 1;
    localparam int unsigned ST_SERVE_BIT = 2;
    localparam int unsigned ST_BER_BIT = 3;
    localparam int unsigned ST_ERRORED_BIT = 4;
    localparam int unsigned ST_CARRIER_BIT = 5;
    localparam int unsigned ST_RTS_BIT = 6;
    localparam int unsigned ST_LOCKED_BIT = 7;
    localparam int unsigned ST_W = 8;

    localparam int unsigned IRQ_ERR_BIT = 0;
    localparam int unsigned IRQ_LOOP_ON_BIT = 1;
    localparam int unsigned IRQ_LOOP_OFF_BIT = 2;
    localparam int unsigned IRQ_CARRIER_BIT = 3;
    localparam int unsigned IRQ_W = 4;
    localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------------
    // types
    // ----------------------------------------------------------------------
    typedef enum logic [1:0] {
        LOOP_IDLE,
        LOOP_LOCAL,
        LOOP_REMOTE,
        LOOP_SERVE
    } lbt_loop_t;

    typedef struct packed {
        logic green;
        logic red;
    } lbt_led_t;

    typedef struct packed {
        lbt_led_t power_indicator;
        lbt_led_t transmit_activity_indicator;
        lbt_led_t receive_activity_indicator;
        lbt_led_t rts_indicator;
        lbt_led_t cd_indicator;
        logic test_indicator;
        logic error_indicator;
    } lbt_leds_t;

    typedef struct packed {
        logic analog_sel;
        logic remote_sel;
        logic pattern_right;
        logic pattern_left;
        logic loop_test_disable_switch;
    } lbt_panel_t;

    typedef struct packed {
        logic txd;
        logic rts;
        logic local_loop_req;
        logic remote_loop_req;
    } lbt_term_in_t;

    typedef struct packed {
        logic rxd;
        logic carrier;
        logic loop_req;
    } lbt_fiber_in_t;

endpackage

// ==== src/lbt_prbs9.sv ====
// Purpose: nine-stage pattern generator and self-synchronising checker
// Assumes: steps come as one-cycle pulses from the owner
// Notes: the checker ignores the first nine bits after restart
`timescale 1ns/100ps
module lbt_prbs9
    import lbt_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic restart,
    input wire logic gen_step,
    input wire logic chk_step,
    input wire logic inject,
    // pattern
    input wire logic rx_bit,
    output logic tx_bit,
    output logic err_pulse,
    output logic locked
);

    typedef struct packed {
        logic [8:0] gen;
        logic [8:0] chk;
        logic [3:0] fill;
        logic [7:0] inj_cnt;
        logic tx;
        logic err;
    } lbt_prbs_state_t;

    lbt_prbs_state_t r;
    lbt_prbs_state_t next_r;
    logic gen_fb;
    logic chk_pred;

    // --------------------------------------------------------------------
    // generator and checker
    // --------------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.err = 1'b0;
        gen_fb = r.gen[PRBS_LEN-1] ^ r.gen[PRBS_TAP-1];
        chk_pred = r.chk[PRBS_LEN-1] ^ r.chk[PRBS_TAP-1];
        if (restart) begin
            next_r.gen = PRBS_SEED;
            next_r.chk = 9'h000;
            next_r.fill = 4'h0;
            next_r.inj_cnt = 8'h00;
        end else begin
            if (gen_step) begin
                next_r.gen = {r.gen[7:0], gen_fb};
                next_r.inj_cnt = (r.inj_cnt == 8'(ERR_INSERT_BITS - 1)) ?
                    8'h00 : r.inj_cnt + 8'h01;
                // errored variant flips one bit per period
                next_r.tx = gen_fb ^ (inject && r.inj_cnt == 8'h00);
            end
            if (chk_step) begin
                next_r.chk = {r.chk[7:0], rx_bit};
                if (r.fill == 4'(PRBS_LEN)) begin
                    next_r.err = rx_bit != chk_pred;
                end else begin
                    next_r.fill = r.fill + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '{gen: PRBS_SEED, chk: 9'h000, fill: 4'h0,
                   inj_cnt: 8'h00, tx: 1'b1, err: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign tx_bit = r.tx;
    assign err_pulse = r.err;
    assign locked = r.fill == 4'(PRBS_LEN);

endmodule

// ==== src/lbt_loopback_ber.sv ====
// Purpose: loopback selection, bit-error test and front lamps of a modem
// Assumes: panel, terminal and fiber inputs are asynchronous to aclk
// Notes: registers on AXI4-Lite; one interrupt output
`timescale 1ns/100ps
module lbt_loopback_ber
    import lbt_pkg::*;
#(
    parameter int unsigned BIT_CYCLES = BER_BIT_CYCLES,
    parameter int unsigned ERR_STRETCH_CYCLES = ERR_LED_CYCLES
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // front panel
    input wire lbt_panel_t panel,
    // terminal side
    input wire lbt_term_in_t term_in,
    output logic term_rxd,
    output logic term_cd,
    // fiber side
    input wire lbt_fiber_in_t fiber_in,
    output logic fiber_txd,
    output logic fiber_loop_req,
    // lamps
    output lbt_leds_t leds,
    // interrupt
    output logic irq,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    typedef struct packed {
        lbt_panel_t panel_s1;
        lbt_panel_t panel_s2;
        lbt_term_in_t term_s1;
        lbt_term_in_t term_s2;
        lbt_fiber_in_t fiber_s1;
        lbt_fiber_in_t fiber_s2;
        lbt_loop_t loop;
        logic carrier_d;
        logic ber_d;
        logic [15:0] bit_cnt;
        logic [21:0] err_stretch;
        logic [15:0] err_count;
        logic term_rxd;
        logic fiber_txd;
        logic [1:0] ctrl;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_enable;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lbt_state_t;

    lbt_state_t r;
    lbt_state_t next_r;

    logic ber_active;
    logic ber_errored;
    logic line_enable;
    logic in_loop;
    logic gen_step;
    logic chk_step;
    logic tx_bit;
    logic rx_bit;
    logic pat_bit;
    logic err_pulse;
    logic locked;
    logic [IRQ_W-1:0] irq_events;
    logic [ST_W-1:0] status;
    logic do_write;
    logic [31:0] wmask;

    // --------------------------------------------------------------------
    // pattern engine
    // --------------------------------------------------------------------
    lbt_prbs9 u_prbs (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(!ber_active),
        .gen_step(gen_step),
        .chk_step(chk_step),
        .inject(ber_errored),
        .rx_bit(rx_bit),
        .tx_bit(pat_bit),
        .err_pulse(err_pulse),
        .locked(locked)
    );

    // --------------------------------------------------------------------
    // test selection
    // --------------------------------------------------------------------
    always_comb begin
        // pattern test has no line request path
        ber_active = r.panel_s2.pattern_right
            || r.panel_s2.pattern_left;
        ber_errored = r.panel_s2.pattern_left
            && !r.panel_s2.pattern_right;
        line_enable = !r.panel_s2.loop_test_disable_switch
            && !r.ctrl[CTRL_SW_DISABLE_BIT];
        in_loop = r.loop == LOOP_LOCAL || r.loop == LOOP_REMOTE;
        gen_step = ber_active && r.bit_cnt == 16'h0000;
        chk_step = ber_active && in_loop
            && r.bit_cnt == 16'(BIT_CYCLES / 2);
        // transmitter carries the pattern while testing, except in the serve loop
        tx_bit = ber_active ? pat_bit : r.term_s2.txd;
        unique case (r.loop)
            LOOP_LOCAL: rx_bit = tx_bit;
            default: rx_bit = r.fiber_s2.rxd;
        endcase
    end

    // --------------------------------------------------------------------
    // status and events
    // --------------------------------------------------------------------
    always_comb begin
        status = '0;
        status[ST_LOCAL_BIT] = r.loop == LOOP_LOCAL;
        status[ST_REMOTE_BIT] = r.loop == LOOP_REMOTE;
        status[ST_SERVE_BIT] = r.loop == LOOP_SERVE;
        status[ST_BER_BIT] = ber_active;
        status[ST_ERRORED_BIT] = ber_errored;
        status[ST_CARRIER_BIT] = r.fiber_s2.carrier;
        status[ST_RTS_BIT] = r.term_s2.rts;
        status[ST_LOCKED_BIT] = locked;
        irq_events = '0;
        irq_events[IRQ_ERR_BIT] = err_pulse;
        // edges of the loop state against last cycle's copy
        irq_events[IRQ_LOOP_ON_BIT] = in_loop && !r.ber_d;
        irq_events[IRQ_LOOP_OFF_BIT] = !in_loop && r.ber_d;
        irq_events[IRQ_CARRIER_BIT] = r.fiber_s2.carrier != r.carrier_d;
    end

    // --------------------------------------------------------------------
    // bus write decode
    // --------------------------------------------------------------------
    always_comb begin
        do_write = r.aw_have && r.w_have && !r.bvalid;
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = r.w_strb[i] ? 8'hFF : 8'h00;
        end
    end

    // --------------------------------------------------------------------
    // next state
    // --------------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.panel_s1 = panel;
        next_r.panel_s2 = r.panel_s1;
        next_r.term_s1 = term_in;
        next_r.term_s2 = r.term_s1;
        next_r.fiber_s1 = fiber_in;
        next_r.fiber_s2 = r.fiber_s1;
        next_r.carrier_d = r.fiber_s2.carrier;
        next_r.ber_d = in_loop;

        // loop selection, local loop takes priority
        if (r.panel_s2.analog_sel
            || (line_enable && r.term_s2.local_loop_req)) begin
            next_r.loop = LOOP_LOCAL;
        end else if (r.panel_s2.remote_sel
            || (line_enable && r.term_s2.remote_loop_req)) begin
            next_r.loop = LOOP_REMOTE;
        end else if (r.fiber_s2.loop_req) begin
            next_r.loop = LOOP_SERVE;
        end else begin
            next_r.loop = LOOP_IDLE;
        end

        // bit timing of the pattern
        if (!ber_active || r.bit_cnt == 16'(BIT_CYCLES - 1)) begin
            next_r.bit_cnt = 16'h0000;
        end else begin
            next_r.bit_cnt = r.bit_cnt + 16'h0001;
        end

        // error lamp stretch and counter
        if (err_pulse) begin
            next_r.err_stretch = 22'(ERR_STRETCH_CYCLES);
        end else if (r.err_stretch != 22'h000000) begin
            next_r.err_stretch = r.err_stretch - 22'h000001;
        end
        if (r.ctrl[CTRL_CNT_CLEAR_BIT]) begin
            next_r.err_count = 16'h0000;
            next_r.ctrl[CTRL_CNT_CLEAR_BIT] = 1'b0;
        end else if (err_pulse && r.err_count != 16'hFFFF) begin
            next_r.err_count = r.err_count + 16'h0001;
        end

        // data paths
        unique case (r.loop)
            LOOP_LOCAL: begin
                next_r.fiber_txd = tx_bit;
                next_r.term_rxd = ber_active ? 1'b1 : rx_bit;
            end
            LOOP_REMOTE: begin
                next_r.fiber_txd = tx_bit;
                next_r.term_rxd = ber_active ? 1'b1 : rx_bit;
            end
            LOOP_SERVE: begin
                // far unit asked us to return its characters
                next_r.fiber_txd = r.fiber_s2.rxd;
                next_r.term_rxd = r.fiber_s2.rxd;
            end
            LOOP_IDLE: begin
                next_r.fiber_txd = tx_bit;
                next_r.term_rxd = r.fiber_s2.rxd;
            end
        endcase

        // write channel
        if (s_axi_awvalid && !r.aw_have && !r.bvalid) begin
            next_r.aw_have = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_have && !r.bvalid) begin
            next_r.w_have = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end

        // sticky status; a new event wins over a clear
        next_r.irq_status = r.irq_status | irq_events;
        if (do_write) begin
            next_r.aw_have = 1'b0;
            next_r.w_have = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = RESP_OKAY;
            unique case ({r.aw_addr[7:2], 2'b00})
                ADDR_CTRL: begin
                    next_r.ctrl = 2'((r.w_data & wmask)
                        | ({30'h0, r.ctrl} & ~wmask));
                end
                ADDR_IRQ_CLEAR: begin
                    next_r.irq_status = (r.irq_status
                        & ~IRQ_W'(r.w_data & wmask)) | irq_events;
                end
                ADDR_IRQ_ENABLE: begin
                    next_r.irq_enable = IRQ_W'((r.w_data & wmask)
                        | ({28'h0, r.irq_enable} & ~wmask));
                end
                ADDR_STATUS, ADDR_ERR_COUNT, ADDR_IRQ_STATUS: begin
                    next_r.bresp = RESP_OKAY;
                end
                default: next_r.bresp = RESP_SLVERR;
            endcase
        end

        // read channel
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !r.rvalid) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                ADDR_CTRL: next_r.rdata = {30'h0, r.ctrl};
                ADDR_STATUS: next_r.rdata = {24'h0, status};
                ADDR_ERR_COUNT: next_r.rdata = {16'h0, r.err_count};
                ADDR_IRQ_STATUS: next_r.rdata = {28'h0, r.irq_status};
                ADDR_IRQ_CLEAR: next_r.rdata = 32'h0;
                ADDR_IRQ_ENABLE: next_r.rdata = {28'h0, r.irq_enable};
                default: begin
                    next_r.rdata = 32'h0;
                    next_r.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // --------------------------------------------------------------------
    // state register
    // --------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.loop <= LOOP_IDLE;
            r.ctrl <= CTRL_RESET;
            r.irq_enable <= IRQ_ENABLE_RESET;
            r.term_rxd <= 1'b1;
            r.fiber_txd <= 1'b1;
            r.term_s1.txd <= 1'b1;
            r.term_s2.txd <= 1'b1;
            r.fiber_s1.rxd <= 1'b1;
            r.fiber_s2.rxd <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // --------------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------------
    assign term_rxd = r.term_rxd;
    assign fiber_txd = r.fiber_txd;
    assign term_cd = r.fiber_s2.carrier;
    assign fiber_loop_req = r.loop == LOOP_REMOTE;
    assign irq = |(r.irq_status & r.irq_enable);

    always_comb begin
        leds.power_indicator = '{green: 1'b1, red: 1'b0};
        // mark (idle) reads red, space reads green
        leds.transmit_activity_indicator =
            '{green: !r.term_s2.txd, red: r.term_s2.txd};
        leds.receive_activity_indicator =
            '{green: !r.term_rxd, red: r.term_rxd};
        leds.rts_indicator =
            '{green: r.term_s2.rts, red: !r.term_s2.rts};
        leds.cd_indicator =
            '{green: r.fiber_s2.carrier, red: !r.fiber_s2.carrier};
        leds.test_indicator = in_loop;
        leds.error_indicator = r.err_stretch != 22'h000000;
    end

    assign s_axi_awready = !r.aw_have && !r.bvalid;
    assign s_axi_wready = !r.w_have && !r.bvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;

endmodule

// ==== sim/lbt_checker.sv ====
// Purpose: port assertions of the loopback and bit-error test block
// Assumes: lbt_pkg compiled first
// Notes: bound to lbt_loopback_ber
`timescale 1ns/100ps
module lbt_checker
    import lbt_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pins
    input wire lbt_panel_t panel,
    input wire lbt_term_in_t term_in,
    input wire lbt_fiber_in_t fiber_in,
    input wire logic term_rxd,
    input wire logic term_cd,
    input wire logic fiber_loop_req,
    input wire lbt_leds_t leds
);
    wire logic norm = !panel.pattern_right && !panel.pattern_left;
    wire logic nosel = !panel.analog_sel && !panel.remote_sel;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_PWR: assert property (leds.power_indicator == 2'h2)
        else $error("power lamp wrong");
    AST_TXLAMP: assert property ((norm && $stable(term_in.txd))[*4] |->
        leds.transmit_activity_indicator == {!term_in.txd, term_in.txd})
        else $error("transmit lamp wrong");
    AST_RTS: assert property ($stable(term_in.rts)[*4] |->
        leds.rts_indicator == {term_in.rts, !term_in.rts})
        else $error("rts lamp wrong");
    AST_CD: assert property ($stable(fiber_in.carrier)[*4] |->
        term_cd == fiber_in.carrier
        && leds.cd_indicator == {fiber_in.carrier, !fiber_in.carrier})
        else $error("carrier detect wrong");
    AST_LOCAL: assert property (panel.analog_sel[*5] |->
        leds.test_indicator && !fiber_loop_req)
        else $error("local loop not entered");
    AST_REMOTE: assert property ((panel.remote_sel
        && !panel.analog_sel)[*5] |-> fiber_loop_req && leds.test_indicator)
        else $error("remote loop not requested");
    AST_IGNORE: assert property ((panel.loop_test_disable_switch
        && nosel && !fiber_in.loop_req)[*5] |-> !leds.test_indicator)
        else $error("line request not ignored");
    AST_ECHO: assert property ((panel.analog_sel && norm)[*8] |->
        term_rxd == $past(term_in.txd, 3))
        else $error("local echo wrong");
endmodule
bind lbt_loopback_ber lbt_checker i_chk (.aclk, .aresetn, .panel,
    .term_in, .fiber_in, .term_rxd, .term_cd, .fiber_loop_req, .leds);

// ==== sim/lbt_peer_model.sv ====
// Purpose: far modem that loops fiber data back on request
// Assumes: slow adds three cycles of line delay
// Notes: line idles at mark when not looping
`timescale 1ns/100ps
module lbt_peer_model
    import lbt_pkg::*;
(
    input wire logic aclk,
    input wire logic fiber_txd,
    input wire logic fiber_loop_req,
    input wire logic carrier_on,
    input wire logic slow,
    input wire logic peer_loop,
    output lbt_fiber_in_t fiber_in
);
    logic [3:0] dl = 4'hF;
    always @(posedge aclk) begin
        dl <= {dl[2:0], fiber_txd};
    end
    assign fiber_in = '{rxd: !fiber_loop_req ? 1'b1 : slow ? dl[3] : dl[0],
        carrier: carrier_on, loop_req: peer_loop};
endmodule

// ==== sim/test_loopback_ber_test_control.sv ====
// Purpose: self-checking bench of the loopback and bit-error test block
// Assumes: short bit and lamp counts
// Notes: peer model loops fiber data back
`timescale 1ns/100ps
module test_loopback_ber_test_control
    import lbt_pkg::*;
;
    localparam int BC = 16;
    logic aclk = 0, aresetn = 0, carrier_on = 0, slow = 0, err_seen = 0;
    logic peer_loop = 0;
    lbt_panel_t panel = '0;
    lbt_term_in_t term_in = 4'h8;
    lbt_fiber_in_t fiber_in;
    lbt_leds_t leds;
    logic term_rxd, term_cd, fiber_txd, fiber_loop_req, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, got;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int num_errors = 0, checks_done = 0, seed = 26;
    logic q[$];
    lbt_loopback_ber #(.BIT_CYCLES(BC), .ERR_STRETCH_CYCLES(8)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .panel(panel), .term_in(term_in),
        .term_rxd(term_rxd), .term_cd(term_cd), .fiber_in(fiber_in),
        .fiber_txd(fiber_txd), .fiber_loop_req(fiber_loop_req),
        .leds(leds), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    lbt_peer_model i_peer (.aclk(aclk), .fiber_txd(fiber_txd),
        .fiber_loop_req(fiber_loop_req), .carrier_on(carrier_on),
        .slow(slow), .peer_loop(peer_loop), .fiber_in(fiber_in));
    initial begin
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (leds.error_indicator === 1'b1)
            err_seen <= 1'b1;
    end
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic tmo(input int n);
        if (n >= 60) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 60);
        bready <= 1'b0;
        tmo(n);
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 60);
        got = rdata;
        rready <= 1'b0;
        tmo(n);
        chk(32'(rresp), 32'(er));
    endtask
    task automatic echo(input int n, input int hold);
        logic b;
        repeat (n) begin
            b = 1'($random(seed));
            term_in.txd <= b;
            q.push_back(b);
            wt(hold);
            chk(32'(term_rxd), 32'(q.pop_front()));
        end
        term_in.txd <= 1'b1;
    endtask
    initial begin
        wt(4);
        aresetn <= 1'b1;
        wt(4);
        chk(32'(leds), 32'h954);
        chk(32'({term_rxd, fiber_loop_req, irq}), 32'h4);
        rd(ADDR_CTRL, RESP_OKAY);
        chk(got, 32'h0);
        rd(ADDR_IRQ_ENABLE, RESP_OKAY);
        chk(got, 32'h0);
        rd(8'h40, RESP_SLVERR);
        wr(8'h40, 32'h1, RESP_SLVERR);
        term_in.rts <= 1'b1;
        carrier_on <= 1'b1;
        wt(6);
        chk(32'({leds.rts_indicator, leds.cd_indicator, term_cd}),
            32'h15);
        panel.analog_sel <= 1'b1;
        wt(6);
        chk(32'(leds.test_indicator), 32'h1);
        echo(6, 10);
        panel.pattern_right <= 1'b1;
        wr(ADDR_IRQ_ENABLE, 32'h1, RESP_OKAY);
        wt(60 * BC);
        rd(ADDR_STATUS, RESP_OKAY);
        chk(got & 32'h89, 32'h89);
        rd(ADDR_ERR_COUNT, RESP_OKAY);
        chk(got, 32'h0);
        chk(32'({term_rxd, irq}), 32'h2);
        panel.pattern_right <= 1'b0;
        panel.pattern_left <= 1'b1;
        wt(300 * BC);
        rd(ADDR_ERR_COUNT, RESP_OKAY);
        chk(32'({got != 0, err_seen, irq}), 32'h7);
        panel.pattern_left <= 1'b0;
        wr(ADDR_IRQ_ENABLE, 32'h0, RESP_OKAY);
        wt(2);
        chk(32'(irq), 32'h0);
        wr(ADDR_IRQ_ENABLE, 32'h1, RESP_OKAY);
        wt(2);
        chk(32'(irq), 32'h1);
        rd(ADDR_IRQ_STATUS, RESP_OKAY);
        chk(got, 32'hB);
        wr(ADDR_IRQ_CLEAR, 32'h1, RESP_OKAY);
        wr(ADDR_CTRL, 32'h2, RESP_OKAY);
        wt(2);
        rd(ADDR_ERR_COUNT, RESP_OKAY);
        chk(got, 32'h0);
        chk(32'(irq), 32'h0);
        panel.analog_sel <= 1'b0;
        panel.loop_test_disable_switch <= 1'b1;
        term_in.local_loop_req <= 1'b1;
        wt(8);
        chk(32'(leds.test_indicator), 32'h0);
        panel.loop_test_disable_switch <= 1'b0;
        wt(8);
        chk(32'(leds.test_indicator), 32'h1);
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        wt(6);
        chk(32'(leds.test_indicator), 32'h0);
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        term_in.local_loop_req <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            slow <= 1'(i);
            if (i == 1)
                term_in.remote_loop_req <= 1'b1;
            else
                panel.remote_sel <= 1'b1;
            wt(8);
            chk(32'({fiber_loop_req, leds.test_indicator}), 32'h3);
            echo(4, 24);
            panel.remote_sel <= 1'b0;
            term_in.remote_loop_req <= 1'b0;
            wt(8);
            chk(32'(leds.test_indicator), 32'h0);
        end
        peer_loop <= 1'b1;
        wt(8);
        rd(ADDR_STATUS, RESP_OKAY);
        chk(got & 32'h7, 32'h4);
        conclude();
    end
endmodule
